/* hdl/nibble_ops_exec.sv */
// decode and one-cycle execution of rotate, return and subtract-with-borrow
`timescale 1ns/1ps
`default_nettype none

module nibble_ops_exec (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire logic [3:0]  mem_rdata,
	input  wire logic [3:0]  wreg_rdata,
	input  wire logic [10:0] stack_top,
	output logic      [3:0]  result_nibble_reg,
	output logic             carry_flag,
	output logic             zero_flag,
	output logic             mem_we,
	output logic      [6:0]  mem_waddr,
	output logic      [3:0]  mem_wdata,
	output logic             wreg_we,
	output logic      [3:0]  wreg_waddr,
	output logic      [3:0]  wreg_wdata,
	output logic             pc_load,
	output logic      [10:0] pc_value,
	output logic             stack_pop,
	output logic             op_done,
	output logic             op_unknown
);

	// decode shared by the execute path and the unknown-word flag; return
	// is matched on the whole word first, the other patterns are disjoint,
	// and the return word matches none of them, so the order of the tests below never changes the decoded op
	function automatic nibble_ops_pkg::op_type decode_op(
		input logic [15:0] word
	);
		logic [8:0] op9;
		logic [7:0] op8;
		op9 = word[15:nibble_ops_pkg::OP9_LSB];
		op8 = word[15:nibble_ops_pkg::OP8_LSB];
		if (word == nibble_ops_pkg::WORD_RETURN) begin
			decode_op = nibble_ops_pkg::OP_RETURN;
		end else if (op9 == nibble_ops_pkg::OP9_ROTATE_RIGHT) begin
			decode_op = nibble_ops_pkg::OP_ROTATE_RIGHT;
		end else if (op9 == nibble_ops_pkg::OP9_SUB_MEM) begin
			decode_op = nibble_ops_pkg::OP_SUB_MEM;
		end else if (op9 == nibble_ops_pkg::OP9_SUB_MEM_WB) begin
			decode_op = nibble_ops_pkg::OP_SUB_MEM_WB;
		end else if (op8 == nibble_ops_pkg::OP8_SUB_IMM) begin
			decode_op = nibble_ops_pkg::OP_SUB_IMM;
		end else if (op8 == nibble_ops_pkg::OP8_SUB_IMM_WB) begin
			decode_op = nibble_ops_pkg::OP_SUB_IMM_WB;
		end else begin
			decode_op = nibble_ops_pkg::OP_NONE;
		end
	endfunction

	nibble_ops_pkg::op_type op;
	logic [6:0] mem_addr;
	logic [3:0] wreg_sel;
	logic [3:0] imm;
	logic [3:0] alu_a;
	logic [3:0] alu_b;
	logic       alu_rot;
	logic [3:0] alu_res;
	logic       alu_carry;
	logic       flags_upd;
	logic       is_mem_op;

	// instruction fields; the partner reads memory and the working
	// register at these same fields within the cycle
	assign mem_addr = instr_word[nibble_ops_pkg::MEM_ADDR_LSB +:
		nibble_ops_pkg::MEM_ADDR_W];
	assign wreg_sel = instr_word[nibble_ops_pkg::WREG_SEL_LSB +:
		nibble_ops_pkg::WREG_SEL_W];
	assign imm      = instr_word[nibble_ops_pkg::IMM_LSB +:
		nibble_ops_pkg::NIBBLE_W];

	// nothing is decoded unless the fetch path offers a word
	always_comb begin
		if (instr_valid) begin
			op = decode_op(instr_word);
		end else begin
			op = nibble_ops_pkg::OP_NONE;
		end
	end

	// operand steering into the shared nibble unit
	// memory forms subtract the result register, so it is the default
	always_comb begin
		alu_a     = mem_rdata;
		alu_b     = result_nibble_reg;
		alu_rot   = 1'b0;
		flags_upd = 1'b0;
		is_mem_op = 1'b0;
		unique case (op)
			nibble_ops_pkg::OP_ROTATE_RIGHT: begin
				alu_rot   = 1'b1;
				flags_upd = 1'b1;
				is_mem_op = 1'b1;
			end
			nibble_ops_pkg::OP_SUB_MEM,
			nibble_ops_pkg::OP_SUB_MEM_WB: begin
				flags_upd = 1'b1;
				is_mem_op = 1'b1;
			end
			nibble_ops_pkg::OP_SUB_IMM,
			nibble_ops_pkg::OP_SUB_IMM_WB: begin
				alu_a     = wreg_rdata;
				alu_b     = imm;
				flags_upd = 1'b1;
			end
			nibble_ops_pkg::OP_RETURN,
			nibble_ops_pkg::OP_NONE: begin
				flags_upd = 1'b0;
			end
		endcase
	end

	nibble_alu u_alu (
		.minuend    (alu_a),
		.subtrahend (alu_b),
		.carry_in   (carry_flag),
		.rotate_sel (alu_rot),
		.result     (alu_res),
		.carry_out  (alu_carry)
	);

	// result register: every nibble op lands here in its single cycle
	// return and words outside the slice leave it alone
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			result_nibble_reg <= nibble_ops_pkg::RESULT_RESET;
		end else if (flags_upd) begin
			result_nibble_reg <= alu_res;
		end
	end

	// flags; the rotate and all subtracts share one update path
	// borrow, not carry: a result that went negative sets the flag, so
	// a chained subtract takes one more away on the next nibble
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			carry_flag <= nibble_ops_pkg::CARRY_RESET;
			zero_flag  <= nibble_ops_pkg::ZERO_RESET;
		end else if (flags_upd) begin
			carry_flag <= alu_carry;
			zero_flag  <= (alu_res == 4'h0);
		end
	end

	// memory write-back for the rotate and the write-back subtract
	// the strobe is registered at the edge after the op and the store lands one edge later, so a word offered right
	// behind it that reads the same nibble still sees the old value;
	// the fetch path keeps one word between such a pair
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_we    <= 1'b0;
			mem_waddr <= nibble_ops_pkg::ADDR_RESET;
			mem_wdata <= nibble_ops_pkg::RESULT_RESET;
		end else begin
			mem_we <= (op == nibble_ops_pkg::OP_ROTATE_RIGHT) ||
				(op == nibble_ops_pkg::OP_SUB_MEM_WB);
			if (is_mem_op) begin
				mem_waddr <= mem_addr;
				mem_wdata <= alu_res;
			end
		end
	end

	// working register write-back, only for the write-back immediate form
	// the plain immediate form never touches the working register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wreg_we    <= 1'b0;
			wreg_waddr <= nibble_ops_pkg::WSEL_RESET;
			wreg_wdata <= nibble_ops_pkg::RESULT_RESET;
		end else begin
			wreg_we <= (op == nibble_ops_pkg::OP_SUB_IMM_WB);
			if (op == nibble_ops_pkg::OP_SUB_IMM_WB) begin
				wreg_waddr <= wreg_sel;
				wreg_wdata <= alu_res;
			end
		end
	end

	// return: stack top goes to the program counter, stack pops once
	// the stack lives outside; only the pop pulse leaves from here
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pc_load   <= 1'b0;
			stack_pop <= 1'b0;
			pc_value  <= nibble_ops_pkg::PC_RESET;
		end else begin
			pc_load   <= (op == nibble_ops_pkg::OP_RETURN);
			stack_pop <= (op == nibble_ops_pkg::OP_RETURN);
			if (op == nibble_ops_pkg::OP_RETURN) begin
				pc_value <= stack_top;
			end
		end
	end

	// completion and unknown-word pulses; words outside this slice are
	// left to other decoders, so unknown is advisory only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			op_done    <= 1'b0;
			op_unknown <= 1'b0;
		end else begin
			op_done    <= (op != nibble_ops_pkg::OP_NONE);
			op_unknown <= instr_valid && (op == nibble_ops_pkg::OP_NONE);
		end
	end

endmodule // nibble_ops_exec

`default_nettype wire

/* hdl/nibble_ops_pkg.sv */
// shared encodings and field positions for the nibble instruction slice
package nibble_ops_pkg;

	// instruction word and field geometry
	localparam int INSTR_W     = 16;
	localparam int NIBBLE_W    = 4;
	localparam int MEM_ADDR_W  = 7;
	localparam int WREG_SEL_W  = 4;
	localparam int PC_W        = 11;

	// field positions inside the instruction word
	localparam int MEM_ADDR_LSB  = 0;
	localparam int WREG_SEL_LSB  = 0;
	localparam int IMM_LSB       = 4;
	localparam int OP9_LSB       = 7;
	localparam int OP8_LSB       = 8;

	// leading opcode patterns
	localparam logic [8:0] OP9_ROTATE_RIGHT  = 9'h09B;
	localparam logic [8:0] OP9_SUB_MEM       = 9'h014;
	localparam logic [8:0] OP9_SUB_MEM_WB    = 9'h016;
	localparam logic [7:0] OP8_SUB_IMM       = 8'h0E;
	localparam logic [7:0] OP8_SUB_IMM_WB    = 8'h0F;
	localparam logic [15:0] WORD_RETURN      = 16'h0200;

	// reset values of the core state held here
	localparam logic [3:0]  RESULT_RESET = 4'h0;
	localparam logic        CARRY_RESET  = 1'b0;
	localparam logic        ZERO_RESET   = 1'b0;
	localparam logic [10:0] PC_RESET     = 11'h000;
	localparam logic [6:0]  ADDR_RESET   = 7'h00;
	localparam logic [3:0]  WSEL_RESET   = 4'h0;

	// every supported operation executes in this many machine cycles
	localparam int OP_CYCLES = 1;

	// decoded operations
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ROTATE_RIGHT,
		OP_RETURN,
		OP_SUB_MEM,
		OP_SUB_IMM,
		OP_SUB_MEM_WB,
		OP_SUB_IMM_WB
	} op_type;

endpackage

/* hdl/nibble_alu.sv */
// nibble arithmetic: subtract with borrow and rotate right through carry
`timescale 1ns/1ps
`default_nettype none

module nibble_alu (
	input  wire logic [3:0] minuend,
	input  wire logic [3:0] subtrahend,
	input  wire logic       carry_in,
	input  wire logic       rotate_sel,
	output logic      [3:0] result,
	output logic            carry_out
);

	logic [4:0] diff;

	// five-bit difference so the borrow falls out in the top bit
	always_comb begin
		diff = {1'b0, minuend} - {1'b0, subtrahend} - {4'h0, carry_in};
		if (rotate_sel) begin
			result    = {carry_in, minuend[3:1]};
			carry_out = minuend[0];
		end else begin
			result    = diff[3:0];
			carry_out = diff[4];
		end
	end

endmodule // nibble_alu

`default_nettype wire

/* test/nibble_ops_monitor.sv */
// assertion checker for the nibble instruction slice
`timescale 1ns/1ps
`default_nettype none
module nibble_ops_monitor (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [3:0]  mem_rdata,
	input wire logic [3:0]  wreg_rdata,
	input wire logic [10:0] stack_top,
	input wire logic [3:0]  result_nibble_reg,
	input wire logic        carry_flag,
	input wire logic        zero_flag,
	input wire logic        mem_we,
	input wire logic [6:0]  mem_waddr,
	input wire logic [3:0]  mem_wdata,
	input wire logic        wreg_we,
	input wire logic [3:0]  wreg_wdata,
	input wire logic        pc_load,
	input wire logic [10:0] pc_value,
	input wire logic        op_done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// decoded offers; borrow sits in bit 4 next to the difference
	wire       rot = instr_valid && instr_word[15:7] == 9'h09B;
	wire       smm = instr_valid && instr_word[15:7] == 9'h014;
	wire       smw = instr_valid && instr_word[15:7] == 9'h016;
	wire       sim = instr_valid && instr_word[15:8] == 8'h0E;
	wire       siw = instr_valid && instr_word[15:8] == 8'h0F;
	wire       ret = instr_valid && instr_word == 16'h0200;
	wire [4:0] dm = {1'b0, mem_rdata} - result_nibble_reg - carry_flag;
	wire [4:0] di = {1'b0, wreg_rdata} - instr_word[7:4] - carry_flag;
	wire [4:0] fr = {carry_flag, result_nibble_reg};
	property p_rot;
		rot |=> fr == {$past(mem_rdata[0]), $past(carry_flag),
			$past(mem_rdata[3:1])};
	endproperty
	a_rot: assert property (p_rot) else $error("rotate wrong");
	property p_rwr; rot |=> mem_we && mem_wdata == fr[3:0] && op_done; endproperty
	a_rwr: assert property (p_rwr) else $error("rotate store");
	property p_adr; rot || smw |=> mem_waddr == $past(instr_word[6:0]); endproperty
	a_adr: assert property (p_adr) else $error("bad address");
	property p_ret; ret |=> pc_load && pc_value == $past(stack_top); endproperty
	a_ret: assert property (p_ret) else $error("return wrong");
	property p_smm; smm || smw |=> fr == $past(dm) && mem_we == $past(smw); endproperty
	a_smm: assert property (p_smm) else $error("mem sub wrong");
	property p_sim; sim || siw |=> fr == $past(di) && wreg_we == $past(siw); endproperty
	a_sim: assert property (p_sim) else $error("imm sub wrong");
	property p_wb; smw || siw |=> (mem_we ? mem_wdata : wreg_wdata) == fr[3:0]; endproperty
	a_wb: assert property (p_wb) else $error("write-back data");
	property p_zf; op_done && !pc_load |-> zero_flag == (fr[3:0] == 4'h0); endproperty
	a_zf: assert property (p_zf) else $error("zero flag wrong");
	c_rot: cover property (rot ##1 rot);
	c_ret: cover property (ret);
	c_siw: cover property (siw ##1 carry_flag);
endmodule // nibble_ops_monitor
`default_nettype wire

/* test/core_model.sv */
// behavioural data memory, working registers and return stack
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] instr_word,
	input  wire logic        mem_we,
	input  wire logic [6:0]  mem_waddr,
	input  wire logic [3:0]  mem_wdata,
	input  wire logic        wreg_we,
	input  wire logic [3:0]  wreg_waddr,
	input  wire logic [3:0]  wreg_wdata,
	input  wire logic        stack_pop,
	output logic      [3:0]  mem_rdata,
	output logic      [3:0]  wreg_rdata,
	output logic      [10:0] stack_top
);
	logic [3:0] mem [128];
	logic [3:0] wreg [16];
	// known contents so the bench can work out every operand
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = i[3:0];
		for (int i = 0; i < 16; i++) wreg[i] = ~i[3:0];
		stack_top = 11'h5A3;
	end
	// no write bypass: a nibble is not read in the cycle it is written
	assign mem_rdata = mem[instr_word[6:0]];
	assign wreg_rdata = wreg[instr_word[3:0]];
	always @(posedge clk_sys) begin
		if (mem_we) mem[mem_waddr] <= mem_wdata;
		if (wreg_we) wreg[wreg_waddr] <= wreg_wdata;
		if (stack_pop) stack_top <= stack_top - 11'h111;
	end
endmodule // core_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the nibble instruction slice
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_sys, rst, instr_valid, carry_flag, zero_flag;
	logic        mem_we, wreg_we, pc_load, stack_pop, op_done, op_unknown;
	logic [15:0] instr_word;
	logic [3:0]  mem_rdata, wreg_rdata, result_nibble_reg, mem_wdata;
	logic [3:0]  wreg_waddr, wreg_wdata, r;
	logic [10:0] stack_top, pc_value;
	logic [6:0]  mem_waddr, a;
	logic [4:0]  e;
	int          fail_count = 0;
	int          tests_run = 0;
	nibble_ops_exec DUT (.*);
	core_model u_core (.*);
	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(string n, logic [15:0] x, logic [15:0] g);
		tests_run++;
		if (g !== x) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask
	// valid stays up, so ops can follow back to back
	task automatic op(logic [15:0] w);
		instr_valid = 1;
		instr_word = w;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic idle();
		instr_valid = 0;
		@(posedge clk_sys);
		#1;
	endtask
	// e holds expected borrow and accumulator
	task automatic res();
		chk("acc", e[3:0], result_nibble_reg);
		chk("cf_zf", {e[4], e[3:0] == 0, 1'b1}, {carry_flag, zero_flag, op_done});
	endtask
	task automatic t_rotate();
		for (int i = 0; i < 4; i++) begin
			a = 7'(7'h40 + i * 7);
			r = u_core.mem[a];
			op({9'h09B, a});
			e = {r[0], e[4], r[3:1]};
			res();
			chk("wr", {1'b1, a, e[3:0]}, {mem_we, mem_waddr, mem_wdata});
		end
		idle();
	endtask
	task automatic t_sub_mem();
		for (int k = 0; k < 4; k++) begin
			a = 7'(7'h1F + k);
			r = u_core.mem[a];
			op({k[0] ? 9'h016 : 9'h014, a});
			e = {1'b0, r} - {1'b0, e[3:0]} - e[4];
			res();
			chk("mem_we", k[0], mem_we);
			if (k[0])
				chk("mwb", {a, e[3:0]}, {mem_waddr, mem_wdata});
		end
		idle();
		chk("mem", {e[3:0], 4'h1}, {u_core.mem[34], u_core.mem[33]});
	endtask
	task automatic t_sub_imm();
		for (int k = 0; k < 4; k++) begin
			r = u_core.wreg[k];
			op({k[0] ? 8'h0F : 8'h0E, 4'(4'hE + k), 4'(k)});
			e = {1'b0, r} - {1'b0, 4'(4'hE + k)} - e[4];
			res();
			// address and data hold the last write-back, so only the
			// strobe says anything for the plain form
			if (k[0])
				chk("wwb", {1'b1, 4'(k), e[3:0]}, {wreg_we, wreg_waddr, wreg_wdata});
			else
				chk("wreg_we", 0, wreg_we);
		end
		idle();
		chk("wreg", e[3:0], u_core.wreg[3]);
	endtask
	task automatic t_return();
		for (int k = 0; k < 2; k++) begin
			a = 7'(stack_top);
			op(16'h0200);
			res();
			chk("pc", {2'b11, stack_top}, {pc_load, stack_pop, pc_value});
			idle();
		end
		op(16'h4C80);
		chk("unknown", {2'b10, e}, {op_unknown, op_done, carry_flag, result_nibble_reg});
		idle();
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		rst = 1;
		instr_valid = 0;
		instr_word = 0;
		e = 0;
		repeat (5) @(posedge clk_sys);
		#1 rst = 0;
		chk("reset", 0, {result_nibble_reg, carry_flag, op_done, mem_we});
		t_rotate();
		t_sub_mem();
		t_sub_imm();
		t_return();
		final_report();
	end
	// about 800 cycles, far above the few dozen the tests need
	initial begin
		#20000;
		fail_count++;
		final_report();
	end
endmodule // tb
bind nibble_ops_exec nibble_ops_monitor u_mon (.*);
`default_nettype wire
